// file: tw_bus_if.sv
// the shared open-drain clock and data lines between the ends.
// assumes external pull-ups: a line is low when any end pulls it.
`timescale 1ns/1ps
`default_nettype none
interface tw_bus_if;
  logic m_scl_o;   // host clock out (always 0)
  logic m_scl_oe;  // host pulls clock low
  logic m_sda_o;   // host data out (always 0)
  logic m_sda_oe;  // host pulls data low
  logic d_scl_o;   // device clock out (always 0)
  logic d_scl_oe;  // device stretches clock
  logic d_sda_o;   // device data out (always 0)
  logic d_sda_oe;  // device pulls data low
  logic scl;       // resolved clock line
  logic sda;       // resolved data line
  // wired-and: released everywhere means pulled high
  assign scl = ~((m_scl_oe & ~m_scl_o) | (d_scl_oe & ~d_scl_o));
  assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));
  modport host (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe,
                input scl, sda);
  modport device (output d_scl_o, d_scl_oe, d_sda_o, d_sda_oe,
                  input scl, sda);
endinterface : tw_bus_if
`default_nettype wire

// file: tw_device.sv
// slave end of the two-wire bus: watches the lines, answers its
// address and the general call, receives and sends bytes.
// assumes lclk is a free-running sample clock well above scl, and
// that own_addr and gcall_en only change while the bus is idle.
//
// How it works
// (RL1) data stays still while clock is high
// (RL2) start/stop are data edges during clock high
// (RL3) bus busy from start until stop
// (RL4) start while busy restarts address phase
// (RL5) address packet: seven bits, direction, acknowledge
// (RL6) direction one reads, zero writes
// (RL7) own address acknowledged in ninth period
// (RL8) unable slave leaves data released
// (RL9) after nack master sends stop or restart
// (RL10) address bits shift most significant first
// (RL11) enabled slaves acknowledge general call writes
// (RL12) master never sends general call read
// (RL13) addresses 1111xxx are never answered
// (RL14) data packet: eight bits then acknowledge
// (RL15) data bits shift most significant first
// (RL16) receiver pulls data low to acknowledge
// (RL17) last acceptable byte gets not-acknowledge
// (RL18) master clocks; receiver alone acknowledges
// (RL19) transfer is start, address, data, stop
// (RL20) slave may hold clock low, master waits
// (RL21) stretching only lengthens the low phase
// (RL22) lines only pulled low or released
// (RL23) always track starts, stops and bus busy
`timescale 1ns/1ps
`default_nettype none
module tw_device (
  input  wire logic       mclk,
  input  wire logic       lclk,
  input  wire logic       reset_n,
  input  wire logic       ce,
  tw_bus_if.device        bus,
  input  wire logic [6:0] own_addr,
  input  wire logic       gcall_en,
  input  wire logic       rx_stop,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output var  logic       tx_ready,
  output var  logic       rx_valid,
  output var  logic [7:0] rx_data,
  output var  logic       bus_busy,
  output var  logic       selected
);
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,  // not addressed
    S_ADDR  = 3'b001,  // shifting address byte
    S_AACK  = 3'b010,  // driving address ack
    S_RX    = 3'b011,  // receiving data
    S_RXACK = 3'b100,  // driving data ack
    S_LOAD  = 3'b101,  // fetching byte, clock held
    S_TX    = 3'b110,  // sending data
    S_TXACK = 3'b111   // reading master ack
  } state_type;

  ////////////////////////////////////////////////////////////////
  // link domain synchronisers (never frozen, never reset)
  logic [1:0] rst_l;   // reset_n into lclk
  logic [1:0] ce_l;    // ce into lclk
  logic [1:0] scl_l;   // scl pin
  logic [1:0] sda_l;   // sda pin
  logic [1:0] stp_l;   // rx_stop level
  logic [1:0] gc_l;    // gcall_en level
  logic [1:0] txq_l;   // tx request toggle
  logic [6:0] adr_m;   // own address, first stage
  logic [6:0] adr_s;   // own address, second stage
  always_ff @(posedge lclk) begin
    rst_l <= {rst_l[0], reset_n};
    ce_l  <= {ce_l[0], ce};
    scl_l <= {scl_l[0], bus.scl};
    sda_l <= {sda_l[0], bus.sda};
    stp_l <= {stp_l[0], rx_stop};
    gc_l  <= {gc_l[0], gcall_en};
    adr_m <= own_addr;
    adr_s <= adr_m;
  end

  logic lrst_n;  // link reset, synchronous
  logic lce;     // link enable
  assign lrst_n = rst_l[1];
  assign lce    = ce_l[1];

  ////////////////////////////////////////////////////////////////
  // line edges and bus busy, kept even when not addressed
  logic scl_q_ff;   // last clock sample
  logic sda_q_ff;   // last data sample
  logic busy_ff;    // bus occupied
  logic start_c;    // start or repeated start seen
  logic stop_c;     // stop seen
  logic rise_c;     // clock rising edge
  logic fall_c;     // clock falling edge
  // data moving while clock high is a start or stop
  assign start_c = scl_l[1] & scl_q_ff & sda_q_ff & ~sda_l[1];
  assign stop_c  = scl_l[1] & scl_q_ff & ~sda_q_ff & sda_l[1];
  assign rise_c  = scl_l[1] & ~scl_q_ff;
  assign fall_c  = ~scl_l[1] & scl_q_ff;

  always_ff @(posedge lclk) begin
    if (!lrst_n) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      busy_ff  <= 1'b0;
    end else if (lce) begin
      scl_q_ff <= scl_l[1];
      sda_q_ff <= sda_l[1];
      if (start_c) begin
        busy_ff <= 1'b1;  // see RL2 see RL3 see RL23
      end else if (stop_c) begin
        busy_ff <= 1'b0;  // see RL3 see RL23
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // address match and transfer machine
  state_type  state_ff;  // protocol state
  logic [3:0] cnt_ff;    // bits of the packet taken
  logic [7:0] sh_ff;     // shift register
  logic       sda_oe_ff; // pulling data low
  logic       scl_oe_ff; // stretching the clock
  logic       rw_ff;     // direction of this transfer
  logic       mack_ff;   // master acked our byte
  logic       sel_ff;    // addressed
  logic       rxt_ff;    // toggles per received byte
  logic [7:0] rxb_ff;    // last received byte
  logic       tk_ff;     // toggles per byte taken to send
  logic       zero_ff;   // constant low drive level
  logic [7:0] txd_ff;    // byte offered from mclk side
  logic       hit_c;     // address byte is ours
  logic       tx_av_c;   // a byte waits to be sent

  // reserved addresses never match, gcall only for writes
  assign hit_c = ~stp_l[1] &                          // see RL8
    (((sh_ff[7:1] == adr_s) &
      (adr_s[6:3] != tw_pkg::RSV_PREFIX)) |          // see RL13
     ((sh_ff[7:1] == tw_pkg::GCALL_ADDR) & gc_l[1] &
      ~sh_ff[0]));                                    // see RL11
  assign tx_av_c = txq_l[1] ^ tk_ff;

  always_ff @(posedge lclk) begin
    if (!lrst_n) begin
      state_ff  <= S_IDLE;
      cnt_ff    <= 4'h0;
      sh_ff     <= 8'h00;
      sda_oe_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      rw_ff     <= 1'b0;
      mack_ff   <= 1'b0;
      sel_ff    <= 1'b0;
      rxt_ff    <= 1'b0;
      rxb_ff    <= 8'h00;
      tk_ff     <= 1'b0;
      zero_ff   <= 1'b0;
    end else if (lce) begin
      if (start_c) begin
        // a start at any point reopens the address phase
        state_ff  <= S_ADDR;            // see RL4
        cnt_ff    <= 4'h0;
        sda_oe_ff <= 1'b0;
        scl_oe_ff <= 1'b0;
        sel_ff    <= 1'b0;
      end else if (stop_c) begin
        state_ff  <= S_IDLE;            // see RL19
        sda_oe_ff <= 1'b0;
        scl_oe_ff <= 1'b0;
        sel_ff    <= 1'b0;
      end else begin
        case (state_ff)
          S_ADDR: begin
            if (rise_c) begin
              // sampled only on rising clock, msb first
              sh_ff  <= {sh_ff[6:0], sda_l[1]};  // see RL10 see RL1
              cnt_ff <= cnt_ff + 4'h1;
            end else if (fall_c && cnt_ff == tw_pkg::LAST_BIT) begin
              if (hit_c) begin
                sda_oe_ff <= 1'b1;      // see RL7 see RL5
                sel_ff    <= 1'b1;
                rw_ff     <= sh_ff[0];  // see RL6
                state_ff  <= S_AACK;
              end else begin
                // left released: master must stop or restart
                state_ff  <= S_IDLE;    // see RL8 see RL9
              end
            end
          end
          S_AACK: begin
            if (fall_c) begin
              sda_oe_ff <= 1'b0;
              cnt_ff    <= 4'h0;
              state_ff  <= rw_ff ? S_LOAD : S_RX;
            end
          end
          S_RX: begin
            if (rise_c) begin
              sh_ff  <= {sh_ff[6:0], sda_l[1]};  // see RL15
              cnt_ff <= cnt_ff + 4'h1;
            end else if (fall_c && cnt_ff == tw_pkg::LAST_BIT) begin
              rxb_ff    <= sh_ff;
              rxt_ff    <= ~rxt_ff;
              // no more wanted: leave released as a nack
              sda_oe_ff <= ~stp_l[1];   // see RL16 see RL17 see RL14
              state_ff  <= S_RXACK;
            end
          end
          S_RXACK: begin
            if (fall_c) begin
              sda_oe_ff <= 1'b0;
              cnt_ff    <= 4'h0;
              state_ff  <= S_RX;
            end
          end
          S_LOAD: begin
            // clock is low here; hold it until a byte arrives
            if (tx_av_c) begin
              sh_ff     <= txd_ff;
              sda_oe_ff <= ~txd_ff[7];
              tk_ff     <= ~tk_ff;
              scl_oe_ff <= 1'b0;
              cnt_ff    <= 4'h0;
              state_ff  <= S_TX;
            end else begin
              scl_oe_ff <= 1'b1;        // see RL20 see RL21
            end
          end
          S_TX: begin
            if (rise_c) begin
              cnt_ff <= cnt_ff + 4'h1;
            end else if (fall_c) begin
              if (cnt_ff == tw_pkg::LAST_BIT) begin
                // master owns the ack period
                sda_oe_ff <= 1'b0;      // see RL18
                state_ff  <= S_TXACK;
              end else begin
                // change data only while clock low
                sh_ff     <= {sh_ff[6:0], 1'b0};  // see RL1 see RL15
                sda_oe_ff <= ~sh_ff[6];
              end
            end
          end
          S_TXACK: begin
            if (rise_c) begin
              mack_ff <= ~sda_l[1];
            end else if (fall_c) begin
              state_ff <= mack_ff ? S_LOAD : S_IDLE;  // see RL17
            end
          end
          default: begin
            state_ff  <= S_IDLE;
            sda_oe_ff <= 1'b0;
            scl_oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // open drain: only ever pull low or release
  assign bus.d_sda_oe = sda_oe_ff;  // see RL22
  assign bus.d_scl_oe = scl_oe_ff;  // see RL22
  assign bus.d_sda_o  = zero_ff;
  assign bus.d_scl_o  = zero_ff;

  ////////////////////////////////////////////////////////////////
  // mclk side: toggles and levels from the link domain
  logic [1:0] rxt_m;   // received byte toggle
  logic [1:0] tk_m;    // byte taken toggle
  logic [1:0] busy_m;  // bus busy level
  logic [1:0] sel_m;   // selected level
  always_ff @(posedge mclk) begin
    rxt_m  <= {rxt_m[0], rxt_ff};
    tk_m   <= {tk_m[0], tk_ff};
    busy_m <= {busy_m[0], busy_ff};
    sel_m  <= {sel_m[0], sel_ff};
  end

  logic rxt_q_ff;  // last synced receive toggle
  logic txq_ff;    // toggles per byte offered
  // rxb_ff holds for a whole packet, far longer than the sync
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rxt_q_ff <= 1'b0;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
      bus_busy <= 1'b0;
      selected <= 1'b0;
    end else if (ce) begin
      rxt_q_ff <= rxt_m[1];
      rx_valid <= rxt_m[1] ^ rxt_q_ff;
      if (rxt_m[1] ^ rxt_q_ff) begin
        rx_data <= rxb_ff;
      end
      bus_busy <= busy_m[1];
      selected <= sel_m[1];
    end
  end

  // one byte slot; stays busy until the link side takes it
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      txq_ff   <= 1'b0;
      txd_ff   <= 8'h00;
      tx_ready <= 1'b0;
    end else if (ce) begin
      if (tx_valid && tx_ready) begin
        txd_ff   <= tx_data;
        txq_ff   <= ~txq_ff;
        tx_ready <= 1'b0;
      end else begin
        tx_ready <= (txq_ff == tk_m[1]);
      end
    end
  end

  always_ff @(posedge lclk) begin
    txq_l <= {txq_l[0], txq_ff};
  end
endmodule : tw_device
`default_nettype wire

// file: tw_host.sv
// master end of the two-wire bus: makes scl from mclk by a
// divider and runs start, byte and stop commands.
// assumes the bus pins reach it unsynchronised.
`timescale 1ns/1ps
`default_nettype none
module tw_host #(
  parameter int HALF = tw_pkg::SCL_HALF_CYC  // scl half period
) (
  input  wire logic           mclk,
  input  wire logic           reset_n,
  input  wire logic           ce,
  tw_bus_if.host              bus,
  input  wire logic           cmd_valid,
  input  wire tw_pkg::cmd_type cmd_code,
  input  wire logic [7:0]     cmd_data,
  input  wire logic           cmd_nack,
  output var  logic           cmd_ready,
  output var  logic           rsp_valid,
  output var  logic [7:0]     rsp_data,
  output var  logic           rsp_ack,
  output var  logic           bus_busy
);
  typedef enum logic [3:0] {
    H_IDLE = 4'h0,  // bus released
    H_HOLD = 4'h1,  // own bus, clock low
    H_RS0  = 4'h2,  // restart: clock low, data up
    H_RS1  = 4'h3,  // start: clock high, data up
    H_RS2  = 4'h4,  // start: data low
    H_LOW  = 4'h5,  // bit low phase
    H_HIGH = 4'h6,  // bit high phase
    H_SP0  = 4'h7,  // stop: clock low, data low
    H_SP1  = 4'h8,  // stop: clock high
    H_SP2  = 4'h9   // stop: data released
  } state_type;

  ////////////////////////////////////////////////////////////////
  // pin synchronisers and bus watch
  logic [1:0] scl_l;  // scl pin
  logic [1:0] sda_l;  // sda pin
  always_ff @(posedge mclk) begin
    scl_l <= {scl_l[0], bus.scl};
    sda_l <= {sda_l[0], bus.sda};
  end

  logic scl_q_ff;  // last clock sample
  logic sda_q_ff;  // last data sample
  logic busy_ff;   // bus occupied by anyone
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      busy_ff  <= 1'b0;
    end else if (ce) begin
      scl_q_ff <= scl_l[1];
      sda_q_ff <= sda_l[1];
      if (scl_l[1] && scl_q_ff && sda_q_ff && !sda_l[1]) begin
        busy_ff <= 1'b1;  // see RL3
      end else if (scl_l[1] && scl_q_ff && !sda_q_ff && sda_l[1]) begin
        busy_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // command sequencer
  state_type   state_ff;   // sequencer state
  logic [15:0] cnt_ff;     // half period counter
  logic [3:0]  bit_ff;     // bit of the packet
  logic [7:0]  sh_ff;      // shift register
  logic        rd_ff;      // current byte is a read
  logic        nack_ff;    // answer this read with nack
  logic        first_ff;   // next byte is the address
  logic        scl_oe_ff;  // pulling clock low
  logic        sda_oe_ff;  // pulling data low
  logic        zero_ff;    // constant low drive level
  logic        take_c;     // command accepted
  logic        done_c;     // half period over
  assign take_c = cmd_valid & cmd_ready;
  assign done_c = cnt_ff == 16'(HALF - 1);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_ff  <= H_IDLE;
      cnt_ff    <= 16'h0000;
      bit_ff    <= 4'h0;
      sh_ff     <= 8'h00;
      rd_ff     <= 1'b0;
      nack_ff   <= 1'b0;
      first_ff  <= 1'b0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      zero_ff   <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      rsp_ack   <= 1'b0;
    end else if (ce) begin
      rsp_valid <= 1'b0;
      case (state_ff)
        H_IDLE, H_HOLD: begin
          cnt_ff <= 16'h0000;
          if (take_c) begin
            if (cmd_code == tw_pkg::CMD_START) begin
              // repeated start keeps the bus
              state_ff <= (state_ff == H_HOLD) ? H_RS0 : H_RS1;
            end else if (state_ff == H_IDLE ||
                         (first_ff && cmd_code != tw_pkg::CMD_WRITE) ||
                         (first_ff &&
                          cmd_data == tw_pkg::GCALL_READ)) begin
              // refused: no bus activity, answer nack
              rsp_valid <= 1'b1;       // see RL12 see RL19
              rsp_ack   <= 1'b0;
            end else if (cmd_code == tw_pkg::CMD_STOP) begin
              state_ff <= H_SP0;       // see RL9
            end else begin
              sh_ff    <= cmd_data;
              rd_ff    <= (cmd_code == tw_pkg::CMD_READ);
              nack_ff  <= cmd_nack;
              first_ff <= 1'b0;
              bit_ff   <= 4'h0;
              state_ff <= H_LOW;
            end
          end
        end
        H_RS0: begin
          sda_oe_ff <= 1'b0;
          cnt_ff    <= done_c ? 16'h0000 : cnt_ff + 16'h0001;
          if (done_c) begin
            scl_oe_ff <= 1'b0;
            state_ff  <= H_RS1;        // see RL4
          end
        end
        H_RS1, H_SP1: begin
          // time the high phase only once the line is high
          if (scl_l[1]) begin          // see RL20 see RL21
            cnt_ff <= done_c ? 16'h0000 : cnt_ff + 16'h0001;
            if (done_c) begin
              sda_oe_ff <= (state_ff == H_RS1);  // see RL2
              state_ff  <= (state_ff == H_RS1) ? H_RS2 : H_SP2;
            end
          end
        end
        H_RS2: begin
          cnt_ff <= done_c ? 16'h0000 : cnt_ff + 16'h0001;
          if (done_c) begin
            scl_oe_ff <= 1'b1;         // see RL18
            first_ff  <= 1'b1;
            rsp_valid <= 1'b1;
            rsp_ack   <= 1'b1;
            state_ff  <= H_HOLD;
          end
        end
        H_LOW: begin
          // data changes one cycle into the low phase
          if (cnt_ff == 16'h0000) begin  // see RL1
            if (bit_ff == tw_pkg::LAST_BIT) begin
              sda_oe_ff <= rd_ff & ~nack_ff;  // see RL16 see RL17
            end else begin
              sda_oe_ff <= ~rd_ff & ~sh_ff[7];  // see RL10 see RL15
            end
          end
          cnt_ff <= done_c ? 16'h0000 : cnt_ff + 16'h0001;
          if (done_c) begin
            scl_oe_ff <= 1'b0;
            state_ff  <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (scl_l[1]) begin          // see RL20 see RL21
            cnt_ff <= done_c ? 16'h0000 : cnt_ff + 16'h0001;
            if (done_c) begin
              scl_oe_ff <= 1'b1;
              if (bit_ff == tw_pkg::LAST_BIT) begin
                // ninth period: receiver's acknowledge
                sda_oe_ff <= 1'b0;     // see RL5 see RL14
                rsp_ack   <= ~sda_l[1];
                rsp_data  <= sh_ff;
                rsp_valid <= 1'b1;
                state_ff  <= H_HOLD;
              end else begin
                sh_ff    <= {sh_ff[6:0], sda_l[1]};
                bit_ff   <= bit_ff + 4'h1;
                state_ff <= H_LOW;
              end
            end
          end
        end
        H_SP0: begin
          sda_oe_ff <= 1'b1;
          cnt_ff    <= done_c ? 16'h0000 : cnt_ff + 16'h0001;
          if (done_c) begin
            scl_oe_ff <= 1'b0;
            state_ff  <= H_SP1;
          end
        end
        H_SP2: begin
          cnt_ff <= done_c ? 16'h0000 : cnt_ff + 16'h0001;
          if (done_c) begin
            rsp_valid <= 1'b1;
            rsp_ack   <= 1'b1;
            state_ff  <= H_IDLE;
          end
        end
        default: begin
          state_ff  <= H_IDLE;
          scl_oe_ff <= 1'b0;
          sda_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  // ready only while idle on a free bus, or holding our own
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cmd_ready <= 1'b0;
      bus_busy  <= 1'b0;
    end else if (ce) begin
      cmd_ready <= ~take_c & ((state_ff == H_IDLE & ~busy_ff) |
                              (state_ff == H_HOLD));  // see RL3
      bus_busy  <= busy_ff;
    end
  end

  assign bus.m_scl_oe = scl_oe_ff;  // see RL22
  assign bus.m_sda_oe = sda_oe_ff;  // see RL22
  assign bus.m_scl_o  = zero_ff;
  assign bus.m_sda_o  = zero_ff;
endmodule : tw_host
`default_nettype wire

// file: tw_monitor.sv
// line checker for the shared two-wire bus.
// assumes the resolved lines settle between mclk edges.
`timescale 1ns/1ps
`default_nettype none
module tw_monitor (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_scl_o,
  input wire logic m_sda_o,
  input wire logic d_scl_o,
  input wire logic d_sda_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic d_scl_oe,
  input wire logic d_sda_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////
  // data edges while the clock is high mark start and stop
  sequence s_start;
    scl && $rose(m_sda_oe);
  endsequence
  sequence s_stop;
    scl && $fell(m_sda_oe);
  endsequence
  a_only_pull: assert property (!(m_scl_o|m_sda_o|d_scl_o|d_sda_o))
    else $error("line driven high");
  a_dev_data_low: assert property ($changed(d_sda_oe) |-> !scl)
    else $error("device data moved in high");
  a_stretch_low: assert property ($rose(d_scl_oe) |-> !$past(scl))
    else $error("stretch cut high phase");
  a_host_waits: assert property ($rose(m_scl_oe) |-> $past(scl))
    else $error("clock pulled before high");
  a_high_len: assert property ($rose(scl) |-> scl[*8])
    else $error("clock high too short");
  a_data_still: assert property ($rose(scl) |=> $stable(sda)[*6])
    else $error("data moved in high");
  a_start_clock: assert property (s_start |-> ##[1:80] !scl)
    else $error("no clock after start");
  a_stop_idle: assert property (s_stop |=> !m_scl_oe[*8])
    else $error("clock pulled after stop");
endmodule : tw_monitor
`default_nettype wire

// file: tw_pkg.sv
// shared constants for the two-wire bus engine and its host.
// assumes a 50 MHz mclk on the host side.
`default_nettype none
package tw_pkg;
  localparam int MCLK_NS      = 20;    // mclk period
  localparam int SCL_HALF_NS  = 1250;  // least scl half period
  // least time, so round up to whole cycles
  localparam int SCL_HALF_CYC =
    (SCL_HALF_NS + MCLK_NS - 1) / MCLK_NS;
  localparam logic [6:0] GCALL_ADDR = 7'h00;  // general call
  localparam logic [3:0] RSV_PREFIX = 4'hF;   // reserved 1111xxx
  localparam logic [7:0] GCALL_READ = 8'h01;  // gcall + read
  localparam logic [3:0] LAST_BIT   = 4'h8;   // ninth period index
  // host command codes
  typedef enum logic [1:0] {
    CMD_START = 2'b00,
    CMD_WRITE = 2'b01,
    CMD_READ  = 2'b10,
    CMD_STOP  = 2'b11
  } cmd_type;
endpackage : tw_pkg
`default_nettype wire

// file: two_wire_bus_protocol_engine_tb_top.sv
// bench joining the host and device ends over the shared lines.
// assumes the package, interface, ends and monitor compile first.
`timescale 1ns/1ps
`default_nettype none
module two_wire_bus_protocol_engine_tb_top;
  logic            mclk = 0, lclk = 0, reset_n = 0;
  logic            cmd_valid = 0, cmd_nack = 0, tx_valid = 0;
  logic            gcall_en = 0, rx_stop = 0;
  tw_pkg::cmd_type cmd_code = tw_pkg::CMD_START;
  logic [7:0]      cmd_data = 8'h00, tx_data = 8'h00;
  logic [6:0]      own_addr = 7'h2A;
  logic            cmd_ready, rsp_valid, rsp_ack, hbusy, dbusy;
  logic            tx_ready, rx_valid, selected;
  logic [7:0]      rsp_data, rx_data, q;
  logic [7:0]      expq[$];  // bytes the device should take
  int              errors = 0, n_compared = 0, k;
  tw_bus_if bus ();
  tw_host #(.HALF(32)) tw_host_inst (.mclk, .reset_n, .ce(1'b1),
    .bus(bus.host), .cmd_valid, .cmd_code, .cmd_data, .cmd_nack,
    .cmd_ready, .rsp_valid, .rsp_data, .rsp_ack, .bus_busy(hbusy));
  tw_device tw_device_inst (.mclk, .lclk, .reset_n, .ce(1'b1),
    .bus(bus.device), .own_addr, .gcall_en, .rx_stop, .tx_valid,
    .tx_data, .tx_ready, .rx_valid, .rx_data, .bus_busy(dbusy),
    .selected);
  tw_monitor tw_monitor_inst (.mclk, .reset_n, .scl(bus.scl),
    .sda(bus.sda), .m_scl_o(bus.m_scl_o), .m_sda_o(bus.m_sda_o),
    .d_scl_o(bus.d_scl_o), .d_sda_o(bus.d_sda_o),
    .m_scl_oe(bus.m_scl_oe), .m_sda_oe(bus.m_sda_oe),
    .d_scl_oe(bus.d_scl_oe), .d_sda_oe(bus.d_sda_oe));
  always #10 mclk = ~mclk;
  // link clock offset so its edges never meet mclk edges
  initial begin
    #7;
    forever #80 lclk = ~lclk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_bit(input logic g, e);
    chk({7'h00, g}, {7'h00, e});
  endtask : chk_bit
  task automatic tally_and_finish;
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // one host command; reads are always answered with nack
  task automatic cmd(input tw_pkg::cmd_type c, input logic [7:0] d,
                     input logic ea);
    int i;
    do @(posedge mclk); while (cmd_ready !== 1'b1 && ++i < 3000);
    if (i >= 3000) errors++;
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_data <= d;
    cmd_nack <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    i = 0;
    do @(posedge mclk); while (rsp_valid !== 1'b1 && ++i < 3000);
    if (i >= 3000) errors++;
    q = rsp_data;
    chk_bit(rsp_ack, ea);
  endtask : cmd
  task automatic load(input logic [7:0] d);
    int i;
    tx_valid <= 1'b1;
    tx_data <= d;
    do @(posedge mclk); while (tx_ready !== 1'b1 && ++i < 3000);
    if (i >= 3000) errors++;
    tx_valid <= 1'b0;
  endtask : load
  // model: who answers an address, then one byte in the direction rw asks
  task automatic xfer(input logic [6:0] a, input logic rw);
    logic       ak;
    logic [7:0] d;
    int         i;
    ak = ((a == own_addr && a[6:3] != 4'hF) ||
          (a == 7'h00 && gcall_en && !rw)) && !rx_stop;
    d = 8'($urandom);
    if (rw && ak) load(d);
    cmd(tw_pkg::CMD_START, 8'h00, 1'b1);
    cmd(tw_pkg::CMD_WRITE, {a, rw}, ak);
    chk_bit(selected, ak);
    if (ak && !rw) expq.push_back(d);
    if (ak) cmd(rw ? tw_pkg::CMD_READ : tw_pkg::CMD_WRITE, d, !rw);
    if (ak && rw) chk(q, d);
    chk_bit(hbusy, 1'b1);
    chk_bit(dbusy, 1'b1);
    cmd(tw_pkg::CMD_STOP, 8'h00, 1'b1);
    do @(posedge mclk); while (dbusy !== 1'b0 && ++i < 400);
    chk_bit(dbusy, 1'b0);
  endtask : xfer
  // every byte the device reports is checked against the model
  always @(posedge mclk)
    if (rx_valid === 1'b1)
      chk(rx_data, expq.size() ? expq.pop_front() : 8'hXX);
  ////////////////////////////////////////////////////////////
  initial begin
    #1ms;
    errors++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'hBDDAAB99));
    own_addr <= 7'h10 + 7'($urandom % 96);
    repeat (4) @(posedge lclk);
    @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    cmd(tw_pkg::CMD_WRITE, 8'h00, 1'b0);
    // own write, own read, wrong, gcall on/off, unable, reserved
    for (k = 0; k < 7; k++) begin
      gcall_en <= (k == 3);
      rx_stop <= (k == 5);
      @(posedge mclk);
      xfer(k < 2 ? own_addr : k == 2 ? own_addr ^ 7'h01 :
           k < 5 ? 7'h00 : k == 5 ? own_addr : 7'h78, k == 1);
    end
    rx_stop <= 1'b0;
    cmd(tw_pkg::CMD_START, 8'h00, 1'b1);
    cmd(tw_pkg::CMD_STOP, 8'h00, 1'b0);
    cmd(tw_pkg::CMD_WRITE, tw_pkg::GCALL_READ, 1'b0);
    cmd(tw_pkg::CMD_WRITE, {own_addr, 1'b0}, 1'b1);
    // device refuses more data: byte still reported, answered nack
    rx_stop <= 1'b1;
    expq.push_back(8'h5C);
    cmd(tw_pkg::CMD_WRITE, 8'h5C, 1'b0);
    rx_stop <= 1'b0;
    @(posedge mclk);
    xfer(own_addr, 1'b0);
    // a reserved own address must never be answered
    own_addr <= 7'h7B;
    @(posedge mclk);
    xfer(7'h7B, 1'b0);
    chk_bit(expq.size() == 0, 1'b1);
    tally_and_finish();
  end
endmodule : two_wire_bus_protocol_engine_tb_top
`default_nettype wire
